// *** dv/async_serial_channel_tb.sv ***
`timescale 1ns/1ns
module async_serial_channel_tb;
	logic       clk_sys = 1'b0;
	logic       sys_rst = 1'b1;
	logic [7:0] io_addr = 8'h00;
	logic [7:0] io_wdata = 8'h00;
	logic       io_wr = 1'b0;
	logic       io_rd = 1'b0;
	wire  [7:0] io_rdata;
	wire        io_rvalid;
	wire        tx_holding_ready;
	wire  [1:0] serial_rx_pin;
	wire  [1:0] serial_tx_pin;
	wire  [1:0] rx_overrun;
	wire  [1:0] rx_data_avail;
	int         fails = 0;
	int         cmp_count = 0;
	logic [7:0] d;
	time        gap;
	always #50 clk_sys = ~clk_sys;
	async_serial_channel async_serial_channel_inst
	(
		.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr),
		.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .io_rvalid(io_rvalid),
		.tx_holding_ready(tx_holding_ready), .serial_rx_pin(serial_rx_pin),
		.serial_tx_pin(serial_tx_pin), .rx_overrun(rx_overrun),
		.rx_data_avail(rx_data_avail)
	);
	serial_peer serial_peer_inst
	(
		.clk_sys(clk_sys), .serial_tx_pin(serial_tx_pin),
		.serial_rx_pin(serial_rx_pin)
	);
	task check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task io_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		io_addr <= a;
		io_wdata <= v;
		io_wr <= 1'b1;
		@(posedge clk_sys);
		io_wr <= 1'b0;
	endtask
	task io_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk_sys);
		io_rd <= 1'b0;
		#1;
		check({7'h00, io_rvalid}, 8'h01);
		v = io_rdata;
	endtask
	task finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		#(100 * 10000);
		fails++;
		finish_test;
	end
	initial
	begin
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		check({6'h00, serial_tx_pin}, 8'h03);
		check({6'h00, rx_data_avail}, 8'h00);
		// queue nine bytes while the first is still shifting
		for (int i = 0; i < 9; i++)
			io_write(8'h06, 8'h30 + i[7:0]);
		io_write(8'h07, 8'ha5);
		io_read(8'h06, d);
		check(d, 8'h38);
		check({7'h00, tx_holding_ready}, 8'h00);
		repeat (1600) @(posedge clk_sys);
		check(serial_peer_inst.got0.size(), 8'h09);
		check({7'h00, tx_holding_ready}, 8'h01);
		// frames back to back: starts exactly one frame apart
		for (int i = 0; i < 8; i++)
		begin
			gap = serial_peer_inst.st0[i+1] - serial_peer_inst.st0[i];
			check(8'(gap / 100), 8'ha0);
		end
		for (int i = 0; i < 9; i++)
			check(serial_peer_inst.got0[i], 8'h30 + i[7:0]);
		check(serial_peer_inst.got1[0], 8'ha5);
		$display("test transmit done");
		for (int i = 0; i < 3; i++)
			serial_peer_inst.send(0, 8'hc0 + i[7:0]);
		repeat (20) @(posedge clk_sys);
		check({7'h00, rx_data_avail[0]}, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			io_read(8'h08, d);
			check(d, i < 3 ? 8'hc0 + i[7:0] : 8'h00);
		end
		io_read(8'h0a, d);
		check(d, 8'h00);
		io_write(8'h09, 8'h77);
		for (int i = 0; i < 6; i++)
			serial_peer_inst.send(1, 8'h50 + i[7:0]);
		repeat (20) @(posedge clk_sys);
		check({6'h00, rx_overrun}, 8'h02);
		for (int i = 0; i < 6; i++)
		begin
			io_read(8'h09, d);
			check(d, i < 5 ? 8'h50 + i[7:0] : 8'h00);
		end
		$display("test receive done");
		// both transmitters have idled long enough for the start checks
		io_write(8'h06, 8'h5a);
		io_write(8'h07, 8'h3c);
		repeat (200) @(posedge clk_sys);
		check(serial_peer_inst.got0[9], 8'h5a);
		check(serial_peer_inst.got1[1], 8'h3c);
		$display("test idle start done");
		finish_test;
	end
endmodule

// *** dv/serial_buffers_props.sv ***
`timescale 1ns/1ns
module serial_buffers_props
(
	input wire       clk_sys,
	input wire       sys_rst,
	input wire [7:0] io_addr,
	input wire       io_wr,
	input wire       io_rd,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata,
	input wire       io_rvalid,
	input wire       tx_holding_ready,
	input wire [1:0] serial_rx_pin,
	input wire [1:0] serial_tx_pin,
	input wire [1:0] rx_overrun,
	input wire [1:0] rx_data_avail
);
	// ----------------------------------------
	// idle detect: high longer than any frame
	// ----------------------------------------
	reg [7:0] hi [0:1];
	integer   i;
	always @(posedge clk_sys)
	begin
		for (i = 0; i < 2; i = i + 1)
			if (sys_rst || !serial_tx_pin[i])
				hi[i] <= 8'h00;
			else if (hi[i] != 8'hff)
				hi[i] <= hi[i] + 8'h01;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	property p_rd_answer; io_rd |=> io_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered next cycle");
	property p_rd_quiet; !io_rd |=> !io_rvalid; endproperty
	a_rd_quiet: assert property (p_rd_quiet)
		else $error("read valid without read");
	property p_start0;
		io_wr && io_addr == 8'h06 && hi[0] == 8'hff |->
			##2 !serial_tx_pin[0] [*8];
	endproperty
	a_start0: assert property (p_start0)
		else $error("channel 0 start bit missing");
	property p_start1;
		io_wr && io_addr == 8'h07 && hi[1] == 8'hff |->
			##2 !serial_tx_pin[1] [*8];
	endproperty
	a_start1: assert property (p_start1)
		else $error("channel 1 start bit missing");
	// a write one cycle back is popped now and drives the start bit
	property p_idle0;
		hi[0] == 8'hff && serial_tx_pin[0] && !(io_wr && io_addr == 8'h06) &&
			!$past(io_wr && io_addr == 8'h06) |=> serial_tx_pin[0];
	endproperty
	a_idle0: assert property (p_idle0)
		else $error("channel 0 left idle");
	property p_idle1;
		hi[1] == 8'hff && serial_tx_pin[1] && !(io_wr && io_addr == 8'h07) &&
			!$past(io_wr && io_addr == 8'h07) |=> serial_tx_pin[1];
	endproperty
	a_idle1: assert property (p_idle1)
		else $error("channel 1 left idle");
	property p_ovr_hold;
		1'b1 |=> (rx_overrun & $past(rx_overrun)) == $past(rx_overrun);
	endproperty
	a_ovr_hold: assert property (p_ovr_hold)
		else $error("overrun flag dropped");
	property p_ovr_full;
		(rx_overrun & ~$past(rx_overrun) & ~rx_data_avail) == 2'b00;
	endproperty
	a_ovr_full: assert property (p_ovr_full)
		else $error("overrun with empty store");
	property p_unmapped;
		io_rd && (io_addr < 8'h06 || io_addr > 8'h09) |=> io_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");
	c_rx_read: cover property (io_rd && io_addr == 8'h08 && rx_data_avail[0]);
	c_overrun: cover property ($rose(rx_overrun[1]));
	c_tx_full: cover property (!tx_holding_ready);
endmodule
bind async_serial_channel serial_buffers_props serial_buffers_props_inst
(
	.clk_sys(clk_sys), .sys_rst(sys_rst), .io_addr(io_addr), .io_wr(io_wr),
	.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.io_rvalid(io_rvalid), .tx_holding_ready(tx_holding_ready),
	.serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
	.rx_overrun(rx_overrun), .rx_data_avail(rx_data_avail)
);

// *** dv/serial_peer.sv ***
`timescale 1ns/1ns
module serial_peer
(
	input  wire       clk_sys,
	input  wire [1:0] serial_tx_pin,
	output reg  [1:0] serial_rx_pin
);
	logic [7:0] got0 [$];
	logic [7:0] got1 [$];
	time        st0 [$];
	initial
	begin
		serial_rx_pin = 2'b11;
		fork
			listen(0);
			listen(1);
		join_none
	end
	// 8n1, lsb first, 16 clocks a bit
	task automatic send(input int ch, input logic [7:0] b);
		logic [9:0] fr;
		fr = {1'b1, b, 1'b0};
		for (int k = 0; k < 10; k++)
		begin
			@(posedge clk_sys);
			serial_rx_pin[ch] <= fr[k];
			repeat (15) @(posedge clk_sys);
		end
	endtask
	// samples mid-bit, 8 clocks after each edge
	task automatic listen(input int ch);
		logic [7:0] b;
		forever
		begin
			wait (serial_tx_pin[ch] === 1'b1);
			wait (serial_tx_pin[ch] === 1'b0);
			if (ch == 0)
				st0.push_back($time);
			repeat (8) @(posedge clk_sys);
			for (int k = 0; k < 8; k++)
			begin
				repeat (16) @(posedge clk_sys);
				b[k] = serial_tx_pin[ch];
			end
			repeat (16) @(posedge clk_sys);
			if (ch == 0)
				got0.push_back(b);
			else
				got1.push_back(b);
		end
	endtask
endmodule

// *** hdl/async_serial_channel.v ***
`timescale 1ns/1ns
`include "serial_buffers_defines.vh"
// Behaviour
// - The transmit shift stage sends its byte out on serial_tx_pin.
// - A pending holding byte is loaded right after a frame ends, no gap.
// - With nothing to send the transmit pin idles high.
// - A holding byte moves to the shift stage once it is empty.
// - The holding register accepts writes while a byte is shifting.
// - Reading the holding register never disturbs transmission.
// - The receive shift stage assembles bits sampled from serial_rx_pin.
// - A complete received byte moves into receive storage when room exists.
// - Overrun is flagged when a byte completes while one is still held.
// - Received bytes queue in a four-entry first-in first-out store.
// - Reading the receive port returns the oldest queued character.
// - The receive shift stage keeps receiving while the store is full.
// - Receive ports are read-only at I/O addresses 08h and 09h.
// - Holding registers decode at I/O addresses 06h and 07h.
module async_serial_channel
(
	input  wire       clk_sys,
	input  wire       sys_rst,
	input  wire [7:0] io_addr,
	input  wire       io_wr,
	input  wire       io_rd,
	input  wire [7:0] io_wdata,
	output reg  [7:0] io_rdata,
	output reg        io_rvalid,
	output reg        tx_holding_ready,
	input  wire [1:0] serial_rx_pin,
	output reg  [1:0] serial_tx_pin,
	output reg  [1:0] rx_overrun,
	output reg  [1:0] rx_data_avail
);
	localparam TX_IDLE = 2'b01;
	localparam TX_SEND = 2'b10;

	reg  [1:0] rx_sync1;
	reg  [1:0] rx_sync2;
	reg  [7:0] tx_hold_copy [0:1];
	reg  [1:0] tx_state [0:1];
	reg  [9:0] tx_shift_stage [0:1];
	reg  [3:0] tx_bits [0:1];
	reg  [15:0] tx_tick [0:1];
	reg  [7:0] rx_shift_stage [0:1];
	reg  [7:0] rx_hold [0:1];
	reg  [1:0] rx_hold_full;
	reg  [1:0] rx_busy;
	reg  [3:0] rx_bits [0:1];
	reg  [15:0] rx_tick [0:1];
	reg  [7:0] rx_mem [0:1][0:`RX_FIFO_DEPTH-1];
	reg  [1:0] rx_rd_ptr [0:1];
	reg  [1:0] rx_wr_ptr [0:1];
	reg  [2:0] rx_count [0:1];

	wire [1:0] wr_sel;
	wire [1:0] rd_sel;
	wire [1:0] fifo_valid;
	wire [1:0] fifo_pop;
	wire [7:0] fifo_data [0:1];
	wire [1:0] fifo_ready;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// holding write and receive port read decode
	assign wr_sel[0] = io_wr && (io_addr == `ADDR_TX_HOLDING_CH0);
	assign wr_sel[1] = io_wr && (io_addr == `ADDR_TX_HOLDING_CH1);
	assign rd_sel[0] = io_rd && (io_addr == `ADDR_RX_FIFO_PORT_CH0);
	assign rd_sel[1] = io_rd && (io_addr == `ADDR_RX_FIFO_PORT_CH1);
	// registered for a clean port; lags a cycle, but a write in that
	// cycle to a full channel is still dropped by its own fifo
	always @(posedge clk_sys)
	begin
		if (sys_rst)
			tx_holding_ready <= 1'b1;
		else
			tx_holding_ready <= fifo_ready[0] && fifo_ready[1];
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			rx_sync1 <= 2'b11;
			rx_sync2 <= 2'b11;
		end
		else
		begin
			rx_sync1 <= serial_rx_pin;
			rx_sync2 <= rx_sync1;
		end
	end

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			io_rdata  <= `DATA_RESET;
			io_rvalid <= 1'b0;
		end
		else
		begin
			io_rvalid <= io_rd;
			// holding read is a copy only
			if (io_rd && io_addr == `ADDR_TX_HOLDING_CH0)
				io_rdata <= tx_hold_copy[0];
			else if (io_rd && io_addr == `ADDR_TX_HOLDING_CH1)
				io_rdata <= tx_hold_copy[1];
			else if (rd_sel[0] && rx_count[0] != 3'd0)
				io_rdata <= rx_mem[0][rx_rd_ptr[0]];
			else if (rd_sel[1] && rx_count[1] != 3'd0)
				io_rdata <= rx_mem[1][rx_rd_ptr[1]];
			else
				io_rdata <= `DATA_RESET;
		end
	end

	genvar ch;
	generate
	for (ch = 0; ch < 2; ch = ch + 1)
	begin : g_ch
		// --------------------------------------------------------
		// transmit holding buffer
		// --------------------------------------------------------
		// writes queue while shifting; stall via ready
		byte_fifo
		#(
			.WIDTH (8),
			.DEPTH (`TX_FIFO_DEPTH),
			.AW    (`TX_FIFO_AW)
		)
		u_tx_holding
		(
			.clk_sys   (clk_sys),
			.sys_rst   (sys_rst),
			.in_valid  (wr_sel[ch]),
			.in_ready  (fifo_ready[ch]),
			.in_data   (io_wdata),
			.out_valid (fifo_valid[ch]),
			.out_ready (fifo_pop[ch]),
			.out_data  (fifo_data[ch])
		);
		assign fifo_pop[ch] = fifo_valid[ch] &&
			(tx_state[ch] == TX_IDLE ||
			(tx_bits[ch] == `FRAME_BITS - 4'd1 &&
			tx_tick[ch] == `BIT_TICKS - 16'd1));

		// --------------------------------------------------------
		// transmit shift stage
		// --------------------------------------------------------
		always @(posedge clk_sys)
		begin
			if (sys_rst)
			begin
				tx_state[ch]       <= TX_IDLE;
				tx_shift_stage[ch] <= 10'h3ff;
				tx_bits[ch]        <= 4'd0;
				tx_tick[ch]        <= 16'd0;
				tx_hold_copy[ch]   <= `DATA_RESET;
				serial_tx_pin[ch]  <= 1'b1;
			end
			else
			begin
				if (wr_sel[ch])
					tx_hold_copy[ch] <= io_wdata;
				case (tx_state[ch])
				TX_IDLE:
				begin
					serial_tx_pin[ch] <= 1'b1;
					if (fifo_pop[ch])
					begin
						tx_shift_stage[ch] <= {1'b1, fifo_data[ch], 1'b0};
						tx_bits[ch]  <= 4'd0;
						tx_tick[ch]  <= 16'd0;
						tx_state[ch] <= TX_SEND;
						serial_tx_pin[ch] <= 1'b0;
					end
				end
				TX_SEND:
				begin
					serial_tx_pin[ch] <= tx_shift_stage[ch][0];
					if (tx_tick[ch] != `BIT_TICKS - 16'd1)
						tx_tick[ch] <= tx_tick[ch] + 16'd1;
					else
					begin
						tx_tick[ch] <= 16'd0;
						if (tx_bits[ch] != `FRAME_BITS - 4'd1)
						begin
							tx_bits[ch] <= tx_bits[ch] + 4'd1;
							tx_shift_stage[ch] <=
								{1'b1, tx_shift_stage[ch][9:1]};
							serial_tx_pin[ch] <= tx_shift_stage[ch][1];
						end
						else if (fifo_pop[ch])
						begin
							tx_shift_stage[ch] <=
								{1'b1, fifo_data[ch], 1'b0};
							tx_bits[ch] <= 4'd0;
							serial_tx_pin[ch] <= 1'b0;
						end
						else
						begin
							tx_state[ch] <= TX_IDLE;
							serial_tx_pin[ch] <= 1'b1;
						end
					end
				end
				default:
					tx_state[ch] <= TX_IDLE;
				endcase
			end
		end

		// --------------------------------------------------------
		// receive shift stage and fifo
		// --------------------------------------------------------
		always @(posedge clk_sys)
		begin
			if (sys_rst)
			begin
				rx_busy[ch]        <= 1'b0;
				rx_bits[ch]        <= 4'd0;
				rx_tick[ch]        <= 16'd0;
				rx_shift_stage[ch] <= `DATA_RESET;
				rx_hold[ch]        <= `DATA_RESET;
				rx_hold_full[ch]   <= 1'b0;
				rx_overrun[ch]     <= 1'b0;
				rx_rd_ptr[ch]      <= 2'd0;
				rx_wr_ptr[ch]      <= 2'd0;
				rx_count[ch]       <= 3'd0;
				rx_data_avail[ch]  <= 1'b0;
			end
			else
			begin
				if (!rx_busy[ch])
				begin
					if (!rx_sync2[ch])
					begin
						rx_busy[ch] <= 1'b1;
						rx_bits[ch] <= 4'd0;
						rx_tick[ch] <= `BIT_TICKS_HALF;
					end
				end
				else if (rx_tick[ch] != `BIT_TICKS - 16'd1)
					rx_tick[ch] <= rx_tick[ch] + 16'd1;
				else
				begin
					rx_tick[ch] <= 16'd0;
					rx_bits[ch] <= rx_bits[ch] + 4'd1;
					if (rx_bits[ch] == 4'd0 && rx_sync2[ch])
						rx_busy[ch] <= 1'b0;
					else if (rx_bits[ch] >= 4'd1 && rx_bits[ch] <= 4'd8)
						rx_shift_stage[ch] <=
							{rx_sync2[ch], rx_shift_stage[ch][7:1]};
					else if (rx_bits[ch] == 4'd9)
					begin
						rx_busy[ch] <= 1'b0;
						// keeps shifting; overrun on full hold
						if (rx_hold_full[ch])
							rx_overrun[ch] <= 1'b1;
						else
						begin
							rx_hold[ch]      <= rx_shift_stage[ch];
							rx_hold_full[ch] <= 1'b1;
						end
					end
				end
				if (rx_hold_full[ch] && rx_count[ch] != 3'd4 &&
					!(rx_busy[ch] && rx_bits[ch] == 4'd9 &&
					rx_tick[ch] == `BIT_TICKS - 16'd1))
				begin
					rx_mem[ch][rx_wr_ptr[ch]] <= rx_hold[ch];
					rx_wr_ptr[ch]    <= rx_wr_ptr[ch] + 2'd1;
					rx_hold_full[ch] <= 1'b0;
				end
				if (rd_sel[ch] && rx_count[ch] != 3'd0)
					rx_rd_ptr[ch] <= rx_rd_ptr[ch] + 2'd1;
				rx_count[ch] <= rx_count[ch]
					+ {2'd0, rx_hold_full[ch] && rx_count[ch] != 3'd4 &&
					!(rx_busy[ch] && rx_bits[ch] == 4'd9 &&
					rx_tick[ch] == `BIT_TICKS - 16'd1)}
					- {2'd0, rd_sel[ch] && rx_count[ch] != 3'd0};
				rx_data_avail[ch] <= (rx_count[ch] != 3'd0);
			end
		end
	end
	endgenerate
endmodule

// *** hdl/byte_fifo.v ***
`timescale 1ns/1ns
module byte_fifo
#(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
)
(
	input  wire             clk_sys,
	input  wire             sys_rst,
	input  wire             in_valid,
	output wire             in_ready,
	input  wire [WIDTH-1:0] in_data,
	output wire             out_valid,
	input  wire             out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr;
	reg [AW-1:0]    rd_ptr;
	reg [AW:0]      count;
	wire            push;
	wire            pop;
	assign in_ready  = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	always @(posedge clk_sys)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
	always @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count  <= {(AW+1){1'b0}};
		end
		else
		begin
			// pointers wrap at DEPTH-1 by compare, so any depth up to 2**AW works
			if (push)
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ?
					{AW{1'b0}} : rd_ptr + 1'b1;
			if (push && !pop)
				count <= count + 1'b1;
			else if (pop && !push)
				count <= count - 1'b1;
		end
	end
endmodule

// *** hdl/serial_buffers_defines.vh ***
`ifndef SERIAL_BUFFERS_DEFINES_VH
`define SERIAL_BUFFERS_DEFINES_VH
`define ADDR_TX_HOLDING_CH0  8'h06
`define ADDR_TX_HOLDING_CH1  8'h07
`define ADDR_RX_FIFO_PORT_CH0 8'h08
`define ADDR_RX_FIFO_PORT_CH1 8'h09
`define RX_FIFO_DEPTH        4
`define RX_FIFO_AW           2
`define TX_FIFO_DEPTH        8
`define TX_FIFO_AW           3
`define BIT_TICKS            16'd16
`define BIT_TICKS_HALF       16'd8
`define FRAME_BITS           4'd10
`define DATA_RESET           8'h00
`endif
